// >>> hw/acc_rotate_map.svh
// Constants for the accumulator rotate and set-bit datapath
`ifndef ACC_ROTATE_MAP_SVH
`define ACC_ROTATE_MAP_SVH

`define ACC_RESET        8'h00
`define CARRY_RESET      1'b0
`define PORT_ONE_RESET   8'hFF
`define RD_DATA_RESET    1'b0
`define BIT_RAM_BITS     128
`define BIT_RAM_RESET    128'h0
`define BIT_RAM_TOP      8'h7F
`define PORT_ONE_BASE    8'h90
`define PORT_ONE_MASK    8'hF8
`define PORT_ONE_BIT_LSB 0
`define PORT_ONE_BIT_MSB 2
`define ACC_MSB          7
`define ACC_LSB          0
`define OP_CYCLES        1

`endif

// >>> hw/acc_rotate_pkg.sv
// Types shared by the rotate and set-bit datapath
package acc_rotate_pkg;

   typedef enum logic [4:0] {
      OP_IDLE            = 5'h01,
      ROTATE_ACC_RIGHT   = 5'h02,
      ROTATE_ACC_RIGHT_VIA_CARRY = 5'h04,
      FORCE_BIT_HIGH_C   = 5'h08,
      FORCE_BIT_HIGH_ADR = 5'h10
   } op_t;

   typedef struct packed {
      op_t        op;
      logic [7:0] bit_addr;
   } op_req_t;

   typedef struct packed {
      logic       valid;
      logic [7:0] bit_addr;
   } bit_wr_t;

   typedef struct packed {
      logic       is_ram;
      logic [6:0] ram_idx;
      logic       is_port;
      logic [2:0] port_bit;
      logic       is_other;
   } bit_target_t;

endpackage : acc_rotate_pkg

// >>> hw/bit_target_decode.sv
// Decodes a direct bit address into bit RAM, port latch or other space
`timescale 1ns/1ps
`include "acc_rotate_map.svh"

module bit_target_decode
   import acc_rotate_pkg::*;
(
   input  wire logic [7:0] bit_addr,   // Direct bit address
   output bit_target_t     target      // Decoded target
);

   wire logic in_ram  = (bit_addr <= `BIT_RAM_TOP);
   wire logic in_port = ((bit_addr & `PORT_ONE_MASK) == `PORT_ONE_BASE);

   // Remaining special bits belong to other core registers
   assign target = '{is_ram:   in_ram,
                     ram_idx:  bit_addr[6:0],
                     is_port:  in_port,
                     port_bit: bit_addr[`PORT_ONE_BIT_MSB:`PORT_ONE_BIT_LSB],
                     is_other: ~in_ram & ~in_port};

endmodule : bit_target_decode

// >>> hw/accumulator_rotate_setbit_unit.sv
// Accumulator rotate right, rotate through carry and set-bit datapath
// Function
// - Plain rotate right moves every accumulator bit one place down and bit 0 wraps to bit 7.
// - Plain rotate right leaves every flag, carry included, as it was.
// - Rotate through carry turns accumulator and carry as one nine-bit ring one place right.
// - Rotate through carry loads old bit 0 into carry and old carry into bit 7.
// - Rotate through carry changes no flag except carry.
// - Set-bit forces the chosen bit to one whatever it held.
// - Set-bit may target the carry or any directly bit-addressable bit.
// - Set-bit changes only the target bit and no other flag.
// - Set-bit on a port latch bit changes that latch and the driven port output with it.
`timescale 1ns/1ps
`include "acc_rotate_map.svh"

module accumulator_rotate_setbit_unit
   import acc_rotate_pkg::*;
(
   input  wire logic       clock,         // Core clock
   input  wire logic       rst_n,         // Async reset, active low
   input  op_req_t         req,           // Decoded operation and bit address
   input  wire logic       acc_load,      // Core writes accumulator
   input  wire logic [7:0] acc_load_data, // Value for accumulator
   input  wire logic       carry_load,    // Core writes carry
   input  wire logic       carry_data,    // Value for carry
   input  wire logic       port_load,     // Core writes port one latch
   input  wire logic [7:0] port_load_data, // Value for port one latch
   input  wire logic [7:0] rd_addr,       // Bit RAM read address
   output logic [7:0]      acc,           // Accumulator
   output logic            carry,         // Carry flag
   output logic [7:0]      port_one,      // Port one output latch
   output logic            rd_data,       // Bit RAM read data
   output bit_wr_t         other_wr,      // Set request for other bits
   output logic            op_done        // Operation completed
);

   logic [7:0]               acc_ff;
   logic [7:0]               nxt_acc;
   logic                     carry_ff;
   logic                     nxt_carry;
   logic [7:0]               port_one_ff;
   logic [7:0]               nxt_port_one;
   logic [`BIT_RAM_BITS-1:0] bit_ram_ff;
   logic                     rd_data_ff;
   bit_wr_t                  other_wr_ff;
   bit_wr_t                  nxt_other_wr;
   logic                     done_ff;
   bit_target_t              tgt;
   wire logic [`BIT_RAM_BITS-1:0] ram_hit;
   wire logic [7:0]          port_hit;

   bit_target_decode u_decode (
      .bit_addr (req.bit_addr),
      .target   (tgt)
   );

   // One-hot op codes, so at most one of these is high
   wire logic do_rr   = (req.op == ROTATE_ACC_RIGHT);
   wire logic do_rrc  = (req.op == ROTATE_ACC_RIGHT_VIA_CARRY);
   wire logic do_setc = (req.op == FORCE_BIT_HIGH_C);
   wire logic do_seta = (req.op == FORCE_BIT_HIGH_ADR);
   wire logic any_op  = do_rr | do_rrc | do_setc | do_seta;

   wire logic set_ram   = do_seta & tgt.is_ram;
   wire logic set_port  = do_seta & tgt.is_port;
   wire logic set_other = do_seta & tgt.is_other;

   wire logic [7:0] acc_rr  = {acc_ff[`ACC_LSB], acc_ff[`ACC_MSB:1]};
   wire logic [7:0] acc_rrc = {carry_ff, acc_ff[`ACC_MSB:1]};

   // Rotates take acc and carry, carry set takes carry; a core load of that register in the same cycle loses
   assign nxt_acc = do_rr  ? acc_rr :
                    do_rrc ? acc_rrc :
                    acc_load ? acc_load_data : acc_ff;

   assign nxt_carry = do_rrc  ? acc_ff[`ACC_LSB] :
                      do_setc ? 1'b1 :
                      do_rr   ? carry_ff :
                      carry_load ? carry_data : carry_ff;

   assign nxt_other_wr = '{valid: set_other, bit_addr: req.bit_addr};

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         acc_ff   <= `ACC_RESET;
         carry_ff <= `CARRY_RESET;
      end else begin
         acc_ff   <= nxt_acc;
         carry_ff <= nxt_carry;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         // Pulses last one cycle; the core samples them on the next edge
         other_wr_ff <= '0;
         done_ff     <= 1'b0;
         rd_data_ff  <= `RD_DATA_RESET;
      end else begin
         other_wr_ff <= nxt_other_wr;
         done_ff     <= any_op;
         rd_data_ff  <= bit_ram_ff[rd_addr[6:0]];
      end
   end

   // Hit vectors keep one writer per register; each bit sets only on its own address
   genvar gi;
   generate
      for (gi = 0; gi < `BIT_RAM_BITS; gi++) begin : g_ram
         assign ram_hit[gi] = set_ram & (tgt.ram_idx == 7'(gi));
      end
      for (gi = 0; gi < 8; gi++) begin : g_port
         assign port_hit[gi] = set_port & (tgt.port_bit == 3'(gi));
      end
   endgenerate

   // Set beats a same-cycle load on its bit; other port bits follow the load
   assign nxt_port_one = (port_load ? port_load_data : port_one_ff) | port_hit;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         bit_ram_ff  <= `BIT_RAM_RESET;
         port_one_ff <= `PORT_ONE_RESET;
      end else begin
         bit_ram_ff  <= bit_ram_ff | ram_hit;
         port_one_ff <= nxt_port_one;
      end
   end

   assign acc      = acc_ff;
   assign carry    = carry_ff;
   assign port_one = port_one_ff;
   assign rd_data  = rd_data_ff;
   assign other_wr = other_wr_ff;
   assign op_done  = done_ff;

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);

   chk_rr_rotate_value: assert property (
      do_rr |=> acc_ff == {$past(acc_ff[0]), $past(acc_ff[7:1])})
      else $error("rotate right gave wrong accumulator");

   chk_rr_carry_kept: assert property (
      do_rr |=> $stable(carry_ff))
      else $error("rotate right changed carry");

   chk_rrc_ring: assert property (
      do_rrc |=> {acc_ff, carry_ff} == {$past(carry_ff), $past(acc_ff)})
      else $error("nine-bit ring rotate wrong");

   chk_rrc_carry_in: assert property (
      do_rrc |=> carry_ff == $past(acc_ff[0]) && acc_ff[7] == $past(carry_ff))
      else $error("carry exchange wrong");

   chk_rrc_no_side: assert property (
      do_rrc |=> ($past(port_load) || $stable(port_one_ff)) && $stable(bit_ram_ff)
                 && !other_wr_ff.valid)
      else $error("rotate through carry touched other state");

   chk_rr_no_side: assert property (
      do_rr |=> ($past(port_load) || $stable(port_one_ff)) && $stable(bit_ram_ff)
                && !other_wr_ff.valid)
      else $error("rotate right touched other state");

   chk_setc_high: assert property (
      do_setc |=> carry_ff && ($past(acc_load) || $stable(acc_ff)))
      else $error("carry not set");

   chk_setc_no_side: assert property (
      do_setc |=> ($past(port_load) || $stable(port_one_ff)) && $stable(bit_ram_ff)
                  && !other_wr_ff.valid)
      else $error("carry set touched other state");

   chk_force_bit_high_ram: assert property (
      set_ram |=> bit_ram_ff[$past(tgt.ram_idx)])
      else $error("addressed bit not set");

   chk_force_bit_high_other: assert property (
      set_other |=> other_wr_ff.valid && other_wr_ff.bit_addr == $past(req.bit_addr))
      else $error("other bit set not forwarded");

   chk_other_quiet: assert property (
      !set_other |=> !other_wr_ff.valid)
      else $error("spurious other bit set");

   chk_force_bit_high_only: assert property (
      do_seta |=> ($past(acc_load) || $stable(acc_ff))
                  && ($past(carry_load) || $stable(carry_ff))
                  && $countones(bit_ram_ff ^ $past(bit_ram_ff)) <= 1)
      else $error("set-bit changed more than its target");

   // Bit RAM has no clear path; a dropped bit means a stray write
   chk_ram_sticky: assert property (
      ($past(bit_ram_ff) & ~bit_ram_ff) == `BIT_RAM_RESET)
      else $error("bit RAM bit cleared");

   chk_port_latch: assert property (
      set_port |=> port_one[$past(tgt.port_bit)]
                   && ($past(port_load) || $countones(port_one ^ $past(port_one)) <= 1))
      else $error("port latch bit not set");

   chk_port_hold: assert property (
      !set_port && !port_load |=> $stable(port_one))
      else $error("port latch changed with no write");

   chk_one_cycle: assert property (
      any_op |=> op_done ##1 (op_done == $past(any_op)))
      else $error("operation not done in one cycle");

   chk_done_quiet: assert property (
      !any_op |=> !op_done)
      else $error("done without an operation");

   // Covers for the main scenarios
   cov_rrc_wrap: cover property (do_rrc && acc_ff[0] && !carry_ff);
   cov_set_port: cover property (set_port ##1 set_port);
   cov_rr_back:  cover property (do_rr ##1 do_rrc ##1 do_setc);
   cov_set_other: cover property (set_other);
   cov_port_merge: cover property (set_port && port_load);

endmodule : accumulator_rotate_setbit_unit

// >>> verification/test_accumulator_rotate_setbit_unit.sv
// Self-checking bench for the rotate and set-bit datapath
`timescale 1ns/1ps
module test_accumulator_rotate_setbit_unit;
   import acc_rotate_pkg::*;
   typedef struct packed {
      logic [7:0]  acc;
      logic        c;
      logic [7:0]  port;
      bit_wr_t     ow;
      logic [31:0] cyc;
   } note_t;
   logic        clock, rst_n, acc_load, carry_load, carry_data, rd_data, op_done, m_c;
   logic        port_load;
   logic [7:0]  acc_load_data, rd_addr, acc, port_one, m_acc, m_port;
   logic [7:0]  port_load_data;
   logic [31:0] cycles, r;
   logic        carry;
   logic [127:0] m_ram;
   op_req_t     req;
   bit_wr_t     other_wr;
   note_t       notes[$];
   note_t       n;
   int          failures, n_checks;
   op_t         ops[5] = '{OP_IDLE, ROTATE_ACC_RIGHT, ROTATE_ACC_RIGHT_VIA_CARRY,
                           FORCE_BIT_HIGH_C, FORCE_BIT_HIGH_ADR};

   accumulator_rotate_setbit_unit dut (.clock(clock), .rst_n(rst_n), .req(req),
      .acc_load(acc_load), .acc_load_data(acc_load_data), .carry_load(carry_load),
      .carry_data(carry_data), .port_load(port_load), .port_load_data(port_load_data),
      .rd_addr(rd_addr), .acc(acc), .carry(carry),
      .port_one(port_one), .rd_data(rd_data), .other_wr(other_wr), .op_done(op_done));

   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end

   task check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task stop_test;
      if (failures == 0 && n_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : stop_test

   // Model applies op on old state, then any load the op does not block
   task step(input op_t op, input logic [7:0] a, input logic ald, input logic [7:0] ad,
             input logic cld, input logic cd, input logic pld = 1'b0,
             input logic [7:0] pd = 8'h00);
      bit_wr_t    ow;
      logic       t;
      logic [7:0] pm;
      @(posedge clock);
      req <= '{op, a};
      acc_load <= ald;
      acc_load_data <= ad;
      carry_load <= cld;
      carry_data <= cd;
      port_load <= pld;
      port_load_data <= pd;
      ow = '0;
      pm = '0;
      case (op)
         ROTATE_ACC_RIGHT: m_acc = {m_acc[0], m_acc[7:1]};
         ROTATE_ACC_RIGHT_VIA_CARRY: begin
            t = m_acc[0];
            m_acc = {m_c, m_acc[7:1]};
            m_c = t;
         end
         FORCE_BIT_HIGH_C: m_c = 1'b1;
         FORCE_BIT_HIGH_ADR: begin
            if (a <= 8'h7F) m_ram[a[6:0]] = 1'b1;
            else if ((a & 8'hF8) == 8'h90) pm[a[2:0]] = 1'b1;
            else ow = '{1'b1, a};
         end
         default: ;
      endcase
      if (ald && !(op inside {ROTATE_ACC_RIGHT, ROTATE_ACC_RIGHT_VIA_CARRY})) m_acc = ad;
      if (cld && !(op inside {ROTATE_ACC_RIGHT, ROTATE_ACC_RIGHT_VIA_CARRY, FORCE_BIT_HIGH_C}))
         m_c = cd;
      if (pld) m_port = pd;
      m_port = m_port | pm;
      if (op != OP_IDLE) notes.push_back('{m_acc, m_c, m_port, ow, cycles + 2});
   endtask : step

   always @(negedge clock) begin
      if (rst_n && op_done === 1'b1) begin
         if (notes.size() == 0) check(32'h1, 32'h0);
         else begin
            n = notes.pop_front();
            check(cycles, n.cyc);
            check({24'h0, acc}, {24'h0, n.acc});
            check({31'h0, carry}, {31'h0, n.c});
            check({24'h0, port_one}, {24'h0, n.port});
            check({23'h0, other_wr.valid, other_wr.valid ? other_wr.bit_addr : 8'h00},
                  {23'h0, n.ow});
         end
      end else if (rst_n) check({31'h0, other_wr.valid}, 32'h0);
   end

   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles > 3000) begin
         failures++;
         stop_test();
      end
   end

   initial begin
      rst_n = 1'b0;
      req = '{OP_IDLE, 8'h00};
      {acc_load, carry_load, carry_data, acc_load_data, rd_addr, port_load, port_load_data} = '0;
      {failures, n_checks, cycles} = '0;
      {m_acc, m_c, m_port, m_ram} = {8'h00, 1'b0, 8'hFF, 128'h0};
      r = $urandom(28510);
      repeat (12) @(posedge clock);
      rst_n <= 1'b1;
      @(negedge clock);
      check({acc, carry, port_one, op_done}, {8'h00, 1'b0, 8'hFF, 1'b0});
      step(OP_IDLE, 8'h00, 1'b1, 8'hC5, 1'b1, 1'b0);
      step(ROTATE_ACC_RIGHT, 8'h00, 1'b1, 8'h11, 1'b0, 1'b0);
      step(ROTATE_ACC_RIGHT_VIA_CARRY, 8'h00, 1'b1, 8'h22, 1'b1, 1'b1);
      step(FORCE_BIT_HIGH_C, 8'h00, 1'b0, 8'h00, 1'b1, 1'b0);
      foreach (ops[i]) step(FORCE_BIT_HIGH_ADR, 8'h7D + 8'h0B * i[7:0], 1'b0, 8'h0, 1'b0, 1'b0);
      step(OP_IDLE, 8'h00, 1'b0, 8'h00, 1'b0, 1'b0, 1'b1, 8'h34);
      step(FORCE_BIT_HIGH_ADR, 8'h90, 1'b0, 8'h00, 1'b0, 1'b0);
      repeat (400) begin
         r = $urandom;
         step(ops[r % 5], r[15:8], r[16], r[31:24], r[17], r[18], r[19] & r[20], r[7:0]);
      end
      repeat (3) step(OP_IDLE, 8'h00, 1'b0, 8'h00, 1'b0, 1'b0);
      check(notes.size(), 32'h0);
      for (int i = 0; i < 128; i++) begin
         @(posedge clock);
         rd_addr <= i[7:0];
         @(posedge clock);
         #1 check({31'h0, rd_data}, {31'h0, m_ram[i]});
      end
      stop_test();
   end
endmodule : test_accumulator_rotate_setbit_unit
